// >>> hw/rx_ovl_top.sv
// receive input routing, gain decode, bit inversion and input overload monitor
// assumes register writes arrive as one-cycle strobes synchronous to CLK_SYS
`timescale 1ns/1ps
`default_nettype none

module rx_ovl_top (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        REG_WR_STB,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        STATUS_RD_STB,
    input  wire logic [1:0]  RX_STATUS_ENABLE_MASK,
    input  wire logic        AUX_D2S_EN_A,
    input  wire logic        AUX_D2S_EN_B,
    input  wire logic        MOD_VALID,
    input  wire logic        MOD_BIT_A,
    input  wire logic        MOD_BIT_B,
    output var  logic        STREAM_IN_READY,
    output var  logic        STREAM_VALID,
    input  wire logic        STREAM_READY,
    output var  logic [1:0]  STREAM_BITS,
    output var  logic        CAL_ROUTE_EN,
    output var  logic        NEG_MIDRAIL_EN,
    output var  logic        PGA_EN_A,
    output var  logic        PGA_EN_B,
    output var  logic        MOD_EN_A,
    output var  logic        MOD_EN_B,
    output var  logic [4:0]  GAIN_DB_A,
    output var  logic [4:0]  GAIN_DB_B,
    output var  logic        MUTE_A,
    output var  logic        MUTE_B,
    output var  logic [1:0]  RX_STATUS_FLAGS,
    output var  logic        RX_CHAN_STATUS,
    output var  logic [15:0] RX_ADC_BIAS_WORD0
);

    import rx_ovl_pkg::*;

    logic [15:0] input_reg;
    logic [15:0] ovf_reg;
    logic [15:0] bias0_reg;
    logic        cal_sel;
    logic [1:0]  ch_en;
    logic [1:0]  ch_inv;
    logic [1:0]  aux_en;
    logic [1:0]  mod_bit;
    logic [1:0]  inv_bits;
    logic        accept;
    logic [1:0]  ovf_hit;
    logic [1:0]  flags_next;
    logic [5:0]  ga;
    logic [5:0]  gb;

    // decode a gain code to signed dB, clamping the unused codes to the range ends
    function automatic logic [5:0] gain_decode(input logic [4:0] code, input logic cal);
        logic [5:0] res;
        res = {1'b0, code};
        if (cal) begin
            res = {1'b0, GAIN_ZERO};
        end else if (code == GAIN_MUTE) begin
            res = {1'b1, GAIN_ZERO};
        end else if (!code[4] && code > GAIN_MAX) begin
            res = {1'b0, GAIN_MAX};
        end else if (code[4] && code < GAIN_MIN) begin
            res = {1'b0, GAIN_MIN};
        end
        return res;
    endfunction

    // register writes; reserved bits are kept at zero whatever the host sends
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            input_reg <= RST_INPUT;
            ovf_reg   <= RST_OVF;
            bias0_reg <= RST_BIAS0;
        end else if (REG_WR_STB) begin
            case (REG_ADDR)
                OFS_INPUT: begin
                    input_reg <= REG_WDATA & MASK_INPUT;
                end
                OFS_OVF: begin
                    ovf_reg <= REG_WDATA & MASK_OVF;
                end
                OFS_BIAS0: begin
                    bias0_reg <= REG_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    assign cal_sel  = input_reg[CAL_SEL_BIT];
    assign aux_en   = {AUX_D2S_EN_B, AUX_D2S_EN_A};
    assign mod_bit  = {MOD_BIT_B, MOD_BIT_A};

    // per-channel control fields, channel a at the low byte
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_ctl
            assign ch_en[gc]    = input_reg[gc*CH_STRIDE+EN_BIT];
            assign ch_inv[gc]   = input_reg[gc*CH_STRIDE+INV_BIT];
            assign inv_bits[gc] = mod_bit[gc] ^ ch_inv[gc];
        end
    endgenerate

    // calibration routing of the positive and negative inputs
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            CAL_ROUTE_EN   <= 1'b0;
            NEG_MIDRAIL_EN <= 1'b0;
        end else begin
            CAL_ROUTE_EN   <= cal_sel;
            NEG_MIDRAIL_EN <= cal_sel;
        end
    end

    // gain stage and modulator power; aux monitor wakes only the gain stage
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PGA_EN_A       <= 1'b0;
            PGA_EN_B       <= 1'b0;
            MOD_EN_A       <= 1'b0;
            MOD_EN_B       <= 1'b0;
        end else begin
            PGA_EN_A       <= ch_en[0] | aux_en[0];
            PGA_EN_B       <= ch_en[1] | aux_en[1];
            MOD_EN_A       <= ch_en[0];
            MOD_EN_B       <= ch_en[1];
        end
    end

    // decoded gain with the mute flag on top, ahead of the output flops
    always_comb begin
        ga = gain_decode(input_reg[GAIN_LSB +: 5], cal_sel);
        gb = gain_decode(input_reg[CH_STRIDE+GAIN_LSB +: 5], cal_sel);
    end

    // effective gain per channel
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            GAIN_DB_A <= GAIN_ZERO;
            GAIN_DB_B <= GAIN_ZERO;
        end else begin
            GAIN_DB_A <= ga[4:0];
            GAIN_DB_B <= gb[4:0];
        end
    end

    // mute per channel; cal select overrides a mute code
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            MUTE_A    <= 1'b0;
            MUTE_B    <= 1'b0;
        end else begin
            MUTE_A    <= ga[5];
            MUTE_B    <= gb[5];
        end
    end

    // modulator stream passes through the skid buffer toward the channel filters
    assign accept = MOD_VALID & STREAM_IN_READY;

    rx_skid_buf #(
        .W (2)
    ) u_buf (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .in_valid  (MOD_VALID),
        .in_ready  (STREAM_IN_READY),
        .in_data   (inv_bits),
        .out_valid (STREAM_VALID),
        .out_ready (STREAM_READY),
        .out_data  (STREAM_BITS)
    );

    // running average overload detector, one per channel
    genvar gf;
    generate
        for (gf = 0; gf < 2; gf++) begin : g_filt
            logic [63:0] hist_reg;
            logic [6:0]  cnt32_reg;
            logic [6:0]  cnt64_reg;
            logic        upd_reg;
            logic        run;
            logic        len64;
            logic        ovf_en;
            logic [4:0]  thr;
            logic [7:0]  sum;
            logic [7:0]  mag;

            assign ovf_en = ovf_reg[gf*CH_STRIDE+OVF_EN_BIT];
            assign len64  = ovf_reg[gf*CH_STRIDE+LEN_BIT];
            assign thr    = ovf_reg[gf*CH_STRIDE+THR_LSB +: 5];
            assign run    = accept & ovf_en & ch_en[gf];

            // ones count minus half the window equals the sum of half-weighted bits
            assign sum = len64 ? ({1'b0, cnt64_reg} - {1'b0, HALF_WIN64})
                               : ({1'b0, cnt32_reg} - {1'b0, HALF_WIN32});
            assign mag = sum[7] ? (8'h00 - sum) : sum;

            // bit history of the last 64 accepted bits, newest at the bottom
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST || !ovf_en) begin
                    hist_reg  <= HIST_RST;
                end else if (run) begin
                    hist_reg  <= {hist_reg[62:0], inv_bits[gf]};
                end
            end

            // ones in the 32-bit window: add the newest bit, drop the one leaving
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST || !ovf_en) begin
                    cnt32_reg <= HALF_WIN32;
                end else if (run) begin
                    cnt32_reg <= cnt32_reg + {6'h00, inv_bits[gf]} - {6'h00, hist_reg[31]};
                end
            end

            // ones in the 64-bit window, kept alongside so a length change is instant
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST || !ovf_en) begin
                    cnt64_reg <= HALF_WIN64;
                end else if (run) begin
                    cnt64_reg <= cnt64_reg + {6'h00, inv_bits[gf]} - {6'h00, hist_reg[63]};
                end
            end

            // compare once, the cycle after each update
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    upd_reg <= 1'b0;
                end else begin
                    upd_reg <= run;
                end
            end

            assign ovf_hit[gf] = upd_reg & ovf_en & (mag > {3'h0, thr});
        end
    endgenerate

    // sticky flags; a new hit wins over a clear in the same cycle
    assign flags_next = (RX_STATUS_FLAGS & ~{2{STATUS_RD_STB}}) | ovf_hit;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RX_STATUS_FLAGS <= 2'h0;
        end else begin
            RX_STATUS_FLAGS <= flags_next;
        end
    end

    // summary bit follows the masked flags
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RX_CHAN_STATUS <= 1'b0;
        end else begin
            RX_CHAN_STATUS <= |(flags_next & RX_STATUS_ENABLE_MASK);
        end
    end

    // bias word goes straight to the analogue bias network
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RX_ADC_BIAS_WORD0 <= RST_BIAS0;
        end else begin
            RX_ADC_BIAS_WORD0 <= bias0_reg;
        end
    end

endmodule

`default_nettype wire

// >>> hw/rx_ovl_pkg.sv
// constants for the receive input routing and overload monitor
// assumes one 25 MHz system clock and register writes from the serial control port
// How it works
// - cal select routes cal inputs, midrail negatives
// - cal select forces both gains to 0 dB
// - channel B enable powers stage and modulator
// - channel B invert flips each modulator bit
// - gain code is two's complement dB, 10000 mutes
// - channel A mirrors channel B controls
// - per-channel running average, 32 or 64 window
// - each bit weighs plus or minus half
// - length bit one selects 64, zero 32
// - overflow enable gates filter and flag
// - magnitude above threshold sets overflow flag
// - aux converter enable powers gain stage only
// - modulator bitstream feeds filter and detector
// - summary bit is masked OR of flags

package rx_ovl_pkg;

    // register offsets on the serial control port
    localparam logic [7:0]  OFS_INPUT       = 8'h1d;
    localparam logic [7:0]  OFS_OVF         = 8'h1e;
    localparam logic [7:0]  OFS_BIAS0       = 8'hcb;

    // reset values
    localparam logic [15:0] RST_INPUT       = 16'h0000;
    localparam logic [15:0] RST_OVF         = 16'h0000;
    localparam logic [15:0] RST_BIAS0       = 16'h9333;

    // writable bits; reserved positions are stored as zero
    localparam logic [15:0] MASK_INPUT      = 16'hff7f;
    localparam logic [15:0] MASK_OVF        = 16'h7f7f;

    // per-channel field layout, channel b sits one stride above channel a
    localparam int          CH_STRIDE       = 8;
    localparam int          CAL_SEL_BIT     = 15;
    localparam int          GAIN_LSB        = 0;
    localparam int          INV_BIT         = 5;
    localparam int          EN_BIT          = 6;
    localparam int          THR_LSB         = 0;
    localparam int          OVF_EN_BIT      = 5;
    localparam int          LEN_BIT         = 6;

    // gain code values
    localparam logic [4:0]  GAIN_MUTE       = 5'h10;
    localparam logic [4:0]  GAIN_ZERO       = 5'h00;
    localparam logic [4:0]  GAIN_MAX        = 5'h0c;
    localparam logic [4:0]  GAIN_MIN        = 5'h14;

    // running average window: alternating history gives a zero sum
    localparam logic [63:0] HIST_RST        = 64'h5555_5555_5555_5555;
    localparam logic [6:0]  HALF_WIN32      = 7'h10;
    localparam logic [6:0]  HALF_WIN64      = 7'h20;

endpackage

// >>> hw/rx_skid_buf.sv
// two-entry skid buffer for the modulator bit pairs
// assumes a synchronous active-high reset; all outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module rx_skid_buf #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);

    logic         skid_valid_reg;
    logic [W-1:0] skid_data_reg;
    logic         accept;
    logic         drain;

    assign accept = in_valid & in_ready;
    assign drain  = ~out_valid | out_ready;

    // head entry: refilled from skid first so order is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (drain) begin
            if (skid_valid_reg) begin
                out_valid <= 1'b1;
                out_data  <= skid_data_reg;
            end else if (accept) begin
                out_valid <= 1'b1;
                out_data  <= in_data;
            end else begin
                out_valid <= 1'b0;
            end
        end
    end

    // skid entry catches the word taken while the head is stalled
    always_ff @(posedge clk) begin
        if (rst) begin
            skid_valid_reg <= 1'b0;
            skid_data_reg  <= '0;
        end else if (drain) begin
            skid_valid_reg <= 1'b0;
        end else if (accept) begin
            skid_valid_reg <= 1'b1;
            skid_data_reg  <= in_data;
        end
    end

    // ready is registered: resets low, then low exactly while the skid entry is full
    always_ff @(posedge clk) begin
        if (rst) begin
            in_ready <= 1'b0;
        end else if (drain) begin
            in_ready <= 1'b1;
        end else begin
            in_ready <= ~(skid_valid_reg | accept);
        end
    end

endmodule

`default_nettype wire

// >>> verif/rx_ovl_asserts.sv
// concurrent checks on the ports of the receive routing and overload monitor
// assumes it is bound to rx_ovl_top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none

module rx_ovl_asserts (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic        REG_WR_STB,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic        STATUS_RD_STB,
    input wire logic [1:0]  RX_STATUS_ENABLE_MASK,
    input wire logic        MOD_VALID,
    input wire logic        STREAM_IN_READY,
    input wire logic        STREAM_VALID,
    input wire logic        STREAM_READY,
    input wire logic [1:0]  STREAM_BITS,
    input wire logic        CAL_ROUTE_EN,
    input wire logic        NEG_MIDRAIL_EN,
    input wire logic        PGA_EN_A,
    input wire logic        PGA_EN_B,
    input wire logic        MOD_EN_A,
    input wire logic        MOD_EN_B,
    input wire logic [4:0]  GAIN_DB_A,
    input wire logic [4:0]  GAIN_DB_B,
    input wire logic        MUTE_A,
    input wire logic        MUTE_B,
    input wire logic [1:0]  RX_STATUS_FLAGS,
    input wire logic        RX_CHAN_STATUS
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    // routing, gain and power relations
    a_cal_route_pair: assert property (CAL_ROUTE_EN == NEG_MIDRAIL_EN)
        else $error("cal routing without midrail negatives");
    a_cal_gain_zero: assert property (CAL_ROUTE_EN |-> GAIN_DB_A == 5'h00 && GAIN_DB_B == 5'h00 && !MUTE_A && !MUTE_B)
        else $error("gain not forced to zero under cal");
    a_mod_needs_pga: assert property ((!MOD_EN_A || PGA_EN_A) && (!MOD_EN_B || PGA_EN_B))
        else $error("modulator on without gain stage");
    a_input_write_lands: assert property (REG_WR_STB && REG_ADDR == 8'h1d ##1 !(REG_WR_STB && REG_ADDR == 8'h1d)
        |=> MOD_EN_A == $past(REG_WDATA[6], 2) && MOD_EN_B == $past(REG_WDATA[14], 2)
        && MUTE_B == ($past(REG_WDATA[12:8], 2) == 5'h10 && !$past(REG_WDATA[15], 2)))
        else $error("input register write not reflected");

    // overflow flags and summary
    a_flag_sticky: assert property (RX_STATUS_FLAGS != 2'b00 && !STATUS_RD_STB
        |=> (RX_STATUS_FLAGS & $past(RX_STATUS_FLAGS)) == $past(RX_STATUS_FLAGS))
        else $error("overflow flag dropped without clear");
    a_flag_has_cause: assert property ((RX_STATUS_FLAGS & ~$past(RX_STATUS_FLAGS)) != 2'b00
        |-> $past(MOD_VALID && STREAM_IN_READY, 2))
        else $error("overflow flag without a new bit");
    a_summary_masked: assert property (RX_CHAN_STATUS == |(RX_STATUS_FLAGS & $past(RX_STATUS_ENABLE_MASK)))
        else $error("summary status mismatch");

    // stream output holds under stall
    a_stream_holds: assert property (STREAM_VALID && !STREAM_READY |=> STREAM_VALID && $stable(STREAM_BITS))
        else $error("stream word changed while stalled");
endmodule

bind rx_ovl_top rx_ovl_asserts rx_ovl_asserts_inst (.CLK_SYS, .SYS_RST, .REG_WR_STB, .REG_ADDR, .REG_WDATA,
    .STATUS_RD_STB, .RX_STATUS_ENABLE_MASK, .MOD_VALID, .STREAM_IN_READY, .STREAM_VALID, .STREAM_READY,
    .STREAM_BITS, .CAL_ROUTE_EN, .NEG_MIDRAIL_EN, .PGA_EN_A, .PGA_EN_B, .MOD_EN_A, .MOD_EN_B,
    .GAIN_DB_A, .GAIN_DB_B, .MUTE_A, .MUTE_B, .RX_STATUS_FLAGS, .RX_CHAN_STATUS);

`default_nettype wire

// >>> verif/host_model.sv
// host processor side: register writes and flag clears on the control port
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic        clk,
    output var  logic        wr_stb,
    output var  logic [7:0]  addr,
    output var  logic [15:0] wdata,
    output var  logic        rd_stb
);
    import rx_ovl_pkg::*;

    // idle bus at time zero
    initial begin
        wr_stb = 1'b0;
        addr   = 8'h00;
        wdata  = 16'h0000;
        rd_stb = 1'b0;
    end

    // one-cycle write strobe, reserved bits sent as zero
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d & (a == OFS_INPUT ? MASK_INPUT : a == OFS_OVF ? MASK_OVF : 16'hffff);
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // one-cycle clear of the overflow flags
    task automatic clr();
        @(posedge clk);
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for rx_ovl_top with a host model and a stalling sink
// assumes rx_ovl_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rx_ovl_pkg::*;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, wr_stb, rd_stb, hold = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wdata, bias;
    logic [1:0]  mask = 2'b00, s_bits, flags;
    logic        aux_a = 1'b0, aux_b = 1'b0, mvalid = 1'b0, bit_a = 1'b0, bit_b = 1'b0, s_ready = 1'b0;
    logic        in_rdy, s_valid, cal_en, neg_en, pga_a, pga_b, mod_a, mod_b, mute_a, mute_b, chan_st;
    logic        inv_a = 1'b0, inv_b = 1'b0;
    logic [4:0]  g_a, g_b;
    logic [4:0]  codes [6] = '{5'h10, 5'h14, 5'h0c, 5'h00, 5'h1f, 5'h01};
    logic [31:0] seed = 32'h40fcb889, r;
    logic [1:0]  exp_q [$];
    int          n_fail = 0, samples_checked = 0, cycles = 0;

    host_model host_model_inst (.clk(clk_sys), .wr_stb(wr_stb), .addr(addr), .wdata(wdata), .rd_stb(rd_stb));
    rx_ovl_top rx_ovl_top_inst (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_WR_STB(wr_stb), .REG_ADDR(addr),
        .REG_WDATA(wdata), .STATUS_RD_STB(rd_stb), .RX_STATUS_ENABLE_MASK(mask), .AUX_D2S_EN_A(aux_a),
        .AUX_D2S_EN_B(aux_b), .MOD_VALID(mvalid), .MOD_BIT_A(bit_a), .MOD_BIT_B(bit_b),
        .STREAM_IN_READY(in_rdy), .STREAM_VALID(s_valid), .STREAM_READY(s_ready), .STREAM_BITS(s_bits),
        .CAL_ROUTE_EN(cal_en), .NEG_MIDRAIL_EN(neg_en), .PGA_EN_A(pga_a), .PGA_EN_B(pga_b), .MOD_EN_A(mod_a),
        .MOD_EN_B(mod_b), .GAIN_DB_A(g_a), .GAIN_DB_B(g_b), .MUTE_A(mute_a), .MUTE_B(mute_b),
        .RX_STATUS_FLAGS(flags), .RX_CHAN_STATUS(chan_st), .RX_ADC_BIAS_WORD0(bias));

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [4:0] eg(input logic [4:0] c);
        return (c == GAIN_MUTE) ? 5'h00 : c;
    endfunction

    task automatic results();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t stream got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // offer one pair, hold it until taken, note the expected word
    task automatic send(input logic a, input logic b);
        mvalid <= 1'b1;
        bit_a  <= a;
        bit_b  <= b;
        do @(posedge clk_sys); while (in_rdy !== 1'b1);
        exp_q.push_back({b ^ inv_b, a ^ inv_a});
    endtask

    task automatic feed(input int n, input logic [1:0] pat, input logic rnd);
        logic [31:0] v;
        repeat (n) begin
            v = rnd ? xs() : {30'h0, pat};
            if ((xs() & 32'h7) == 32'h0) begin
                mvalid <= 1'b0;
                @(posedge clk_sys);
            end
            send(v[0], v[1]);
        end
        mvalid <= 1'b0;
        repeat (30) @(posedge clk_sys);
        #1;
    endtask

    // stalling sink and stream monitor
    always @(posedge clk_sys) begin
        s_ready <= !hold && ((xs() & 32'h3) != 32'h0);
        if (s_valid === 1'b1 && s_ready === 1'b1) begin
            if (exp_q.size() == 0) cmp16(16'h0001, 16'h0000, "unexpected word");
            else cmp_bits(s_bits, exp_q.pop_front());
        end
    end

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("CHECK FAILED t=%0t timeout", $time);
            results();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        cmp16(bias, RST_BIAS0, "bias reset");
        host_model_inst.wr(8'h55, 16'hffff);
        r = xs();
        host_model_inst.wr(OFS_BIAS0, r[15:0]);
        settle();
        cmp16({10'h0, flags, mod_a, mod_b, pga_a, pga_b}, 16'h0000, "unmapped write");
        cmp16(bias, r[15:0], "bias write");
        for (int i = 0; i < 6; i++) begin
            host_model_inst.wr(OFS_INPUT, {1'b0, i[0], 1'b0, codes[5 - i], 3'b010, codes[i]});
            settle();
            cmp16({mute_b, mute_a, g_b, g_a, mod_b, mod_a, pga_b, pga_a}, {codes[5 - i] == GAIN_MUTE,
                codes[i] == GAIN_MUTE, eg(codes[5 - i]), eg(codes[i]), i[0], 1'b1, i[0], 1'b1}, "gain");
        end
        host_model_inst.wr(OFS_INPUT, 16'h8c4c);
        settle();
        cmp16({cal_en, neg_en, mute_b, mute_a, g_b, g_a, mod_a, pga_a}, 16'hc003, "cal");
        host_model_inst.wr(OFS_INPUT, 16'h0000);
        aux_a <= 1'b1;
        aux_b <= 1'b1;
        settle();
        cmp16({12'h0, pga_b, pga_a, mod_b, mod_a}, 16'h000c, "aux");
        aux_a <= 1'b0;
        aux_b <= 1'b0;
        for (int k = 1; k >= 0; k--) begin
            host_model_inst.wr(OFS_INPUT, {1'b0, 1'b1, k[0] == 1'b0, 5'h00, 1'b0, 1'b1, k[0], 5'h00});
            settle();
            inv_a = k[0];
            inv_b = !k[0];
            feed(40, 2'b00, 1'b1);
            hold = 1'b1;
            feed(2, 2'b00, 1'b1);
            cmp16({15'h0, in_rdy}, 16'h0000, "full buffer refuses");
            hold = 1'b0;
            feed(0, 2'b00, 1'b0);
            cmp16(16'(exp_q.size()), 16'h0000, "drained");
        end
        host_model_inst.wr(OFS_OVF, 16'h3030);
        mask <= 2'b01;
        feed(80, 2'b11, 1'b0);
        cmp16({14'h0, flags}, 16'h0000, "threshold 16 on 32 window");
        host_model_inst.wr(OFS_OVF, 16'h702f);
        feed(80, 2'b11, 1'b0);
        cmp16({13'h0, chan_st, flags}, 16'h0007, "both polarities flag");
        mask <= 2'b00;
        settle();
        cmp16({13'h0, chan_st, flags}, 16'h0003, "masked summary");
        host_model_inst.wr(OFS_OVF, 16'h0000);
        feed(10, 2'b01, 1'b0);
        cmp16({14'h0, flags}, 16'h0003, "sticky");
        host_model_inst.clr();
        feed(80, 2'b11, 1'b0);
        cmp16({14'h0, flags}, 16'h0000, "disabled never flags");
        results();
    end
endmodule

`default_nettype wire
